// [design/pecrm_top.sv]
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// - capture word two holds bytes 8-11
// - capture word three holds bytes 12-15
// - sixteen port copies, 0x40 apart
// - rate and trigger registers govern reporting
// - decrement periods counted on 100 MHz clock
// - bias zero never decrements
// - codes 01/02/04/08 set short periods
// - codes 10/20/40 set long periods
// - code 80 is reset, 10995 s
// - code FF decrements every 1.28 us
// - recovery caps excess above failed trigger
// - recovery 00=2, 01=4, 10=16, 11=none
// - peak holds highest counter value
// - peak rises with counter, falls only on a rate write
// - counter counts errors, saturates both ways
// - report when counter equals trigger
// - failed trigger, zero disables, resets FF
// - degraded trigger, zero disables, resets FF
module pecrm_top
    import pecrm_pkg::*;
#(
    parameter logic [DIV_W-1:0] P_CYC01 = CYC01,
    parameter logic [DIV_W-1:0] P_CYC02 = CYC02,
    parameter logic [DIV_W-1:0] P_CYC04 = CYC04,
    parameter logic [DIV_W-1:0] P_CYC08 = CYC08,
    parameter logic [DIV_W-1:0] P_CYC10 = CYC10,
    parameter logic [DIV_W-1:0] P_CYC20 = CYC20,
    parameter logic [DIV_W-1:0] P_CYC40 = CYC40,
    parameter logic [DIV_W-1:0] P_CYC80 = CYC80
) (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    // register bus
    input  wire logic [AW-1:0]              reg_addr,
    input  wire logic [DW-1:0]              reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [DW-1:0]              reg_rdata,
    // error detection side, per port
    input  wire logic [NPORT-1:0]           err_event,
    input  wire logic [NPORT-1:0]           capture_stb,
    input  wire logic [NPORT-1:0][DW-1:0]   capture_word_two_in,
    input  wire logic [NPORT-1:0][DW-1:0]   capture_word_three_in,
    // reporting, per port
    output logic      [NPORT-1:0]           failed_report,
    output logic      [NPORT-1:0]           degraded_report
);

    // ----------------------------------------
    // period lookup
    // ----------------------------------------

    // bias code to decrement period, zero = never
    function automatic logic [DIV_W-1:0] period_of(
        input logic [7:0] code
    );
        logic [DIV_W-1:0] per;
        per = '0;
        case (code)
            BIAS_01: per = P_CYC01;
            BIAS_02: per = P_CYC02;
            BIAS_04: per = P_CYC04;
            BIAS_08: per = P_CYC08;
            BIAS_10: per = P_CYC10;
            BIAS_20: per = P_CYC20;
            BIAS_40: per = P_CYC40;
            BIAS_80: per = P_CYC80;
            BIAS_FF: per = CYCFF;
            default: per = '0;      // zero and reserved codes
        endcase
        return per;
    endfunction : period_of

    // ----------------------------------------
    // per-port read words
    // ----------------------------------------
    logic [NPORT-1:0][DW-1:0] rd_cap2;  // capture word two
    logic [NPORT-1:0][DW-1:0] rd_cap3;  // capture word three
    logic [NPORT-1:0][DW-1:0] rd_rate;  // rate monitor word
    logic [NPORT-1:0][DW-1:0] rd_thr;   // trigger word

    // ----------------------------------------
    // port copies
    // ----------------------------------------
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        // base offset of this copy
        localparam logic [15:0] PBASE = 16'(p) * PORT_STRIDE;

        logic [DW-1:0]    capture_word_two;   // bytes 8..11
        logic [DW-1:0]    capture_word_three; // bytes 12..15
        logic [7:0]       decrement_bias_select;
        logic [1:0]       recovery_ceiling_select;
        logic [7:0]       peak;               // highest count seen
        logic [7:0]       leaky_error_counter;
        logic [7:0]       failed_link_trigger;
        logic [7:0]       degraded_link_trigger;
        logic [DIV_W-1:0] div;                // period counter
        logic [DIV_W-1:0] per;                // selected period
        logic             tick;               // decrement pulse
        logic [7:0]       excess;             // recovery allowance
        logic [8:0]       ceil_sum;           // trigger plus excess
        logic [7:0]       ceiling;            // highest legal count
        logic             inc_ok;             // increment allowed
        logic             dec_ok;             // decrement allowed
        logic [7:0]       next_cnt;           // counter after events
        logic [7:0]       next_peak;          // peak after events
        logic             wr_cap2;            // write strobes
        logic             wr_cap3;
        logic             wr_rate;
        logic             wr_thr;

        // address decode for writes
        assign wr_cap2 = reg_wr && (reg_addr == OFF_CAP2 + PBASE);
        assign wr_cap3 = reg_wr && (reg_addr == OFF_CAP3 + PBASE);
        assign wr_rate = reg_wr && (reg_addr == OFF_RATE + PBASE);
        assign wr_thr  = reg_wr && (reg_addr == OFF_THR + PBASE);

        // capture word two: capture wins over write
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                capture_word_two <= RST_CAP;
            end else if (capture_stb[p]) begin
                capture_word_two <= capture_word_two_in[p];
            end else if (wr_cap2) begin
                capture_word_two <= reg_wdata;
            end
        end

        // capture word three: capture wins over write
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                capture_word_three <= RST_CAP;
            end else if (capture_stb[p]) begin
                capture_word_three <= capture_word_three_in[p];
            end else if (wr_cap3) begin
                capture_word_three <= reg_wdata;
            end
        end

        // bias and recovery selects
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                decrement_bias_select   <= RST_RATE[BIAS_LO +: 8];
                recovery_ceiling_select <= RST_RATE[RR_LO +: 2];
            end else if (wr_rate) begin
                decrement_bias_select   <= reg_wdata[BIAS_LO +: 8];
                recovery_ceiling_select <= reg_wdata[RR_LO +: 2];
            end
        end

        // trigger levels
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                failed_link_trigger   <= RST_THR[FT_LO +: 8];
                degraded_link_trigger <= RST_THR[DT_LO +: 8];
            end else if (wr_thr) begin
                failed_link_trigger   <= reg_wdata[FT_LO +: 8];
                degraded_link_trigger <= reg_wdata[DT_LO +: 8];
            end
        end

        // period counter on the 100 MHz bus clock
        assign per  = period_of(decrement_bias_select);
        assign tick = (per != '0) && (div == per - 1'b1);

        always_ff @(posedge mclk) begin
            if (!reset_n || wr_rate || per == '0) begin
                div <= '0;                                      // restart
            end else if (tick) begin
                div <= '0;
            end else begin
                div <= div + 1'b1;
            end
        end

        // recovery ceiling above the failed trigger
        always_comb begin
            case (recovery_ceiling_select)
                RR_2:    excess = EXC_2;
                RR_4:    excess = EXC_4;
                RR_16:   excess = EXC_16;
                default: excess = CNT_MAX;
            endcase
            ceil_sum = {1'b0, failed_link_trigger} + {1'b0, excess};
            if (failed_link_trigger == '0 || recovery_ceiling_select == RR_NONE) begin
                ceiling = CNT_MAX;         // no limit
            end else if (ceil_sum[8]) begin
                ceiling = CNT_MAX;         // sum past top
            end else begin
                ceiling = ceil_sum[7:0];
            end
        end

        // counter and peak next values
        always_comb begin
            inc_ok   = err_event[p] && (leaky_error_counter < ceiling);
            dec_ok   = tick && (leaky_error_counter != '0);
            next_cnt = leaky_error_counter;
            if (inc_ok && !dec_ok) begin
                next_cnt = leaky_error_counter + 8'h01;
            end else if (dec_ok && !inc_ok) begin
                next_cnt = leaky_error_counter - 8'h01;
            end
            next_peak = (next_cnt > peak) ? next_cnt : peak;
        end

        // counter and peak, software write wins
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                leaky_error_counter <= RST_RATE[CNT_LO +: 8];
                peak                <= RST_RATE[PEAK_LO +: 8];
            end else if (wr_rate) begin
                leaky_error_counter <= reg_wdata[CNT_LO +: 8];
                peak                <= reg_wdata[PEAK_LO +: 8];
            end else begin
                leaky_error_counter <= next_cnt;
                peak                <= next_peak;
            end
        end

        // reporting on equality with a live trigger
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                failed_report[p]   <= 1'b0;
                degraded_report[p] <= 1'b0;
            end else begin
                failed_report[p]   <= (failed_link_trigger != '0) &&
                    (leaky_error_counter == failed_link_trigger);
                degraded_report[p] <= (degraded_link_trigger != '0) &&
                    (leaky_error_counter == degraded_link_trigger);
            end
        end

        // read words, reserved bits zero
        assign rd_cap2[p] = capture_word_two;
        assign rd_cap3[p] = capture_word_three;
        assign rd_rate[p] = {decrement_bias_select, 6'h00, recovery_ceiling_select,
                             peak, leaky_error_counter};
        assign rd_thr[p]  = {failed_link_trigger, degraded_link_trigger, 16'h0000};
    end

    // ----------------------------------------
    // read mux and read data flop
    // ----------------------------------------
    logic [DW-1:0] next_rdata; // selected word

    // pick the addressed word, zero when unmapped
    always_comb begin
        next_rdata = '0;
        for (int p = 0; p < NPORT; p++) begin
            if (reg_addr == OFF_CAP2 + 16'(p) * PORT_STRIDE) begin
                next_rdata = rd_cap2[p];
            end
            if (reg_addr == OFF_CAP3 + 16'(p) * PORT_STRIDE) begin
                next_rdata = rd_cap3[p];
            end
            if (reg_addr == OFF_RATE + 16'(p) * PORT_STRIDE) begin
                next_rdata = rd_rate[p];
            end
            if (reg_addr == OFF_THR + 16'(p) * PORT_STRIDE) begin
                next_rdata = rd_thr[p];
            end
        end
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : pecrm_top

// [design/pecrm_pkg.sv]
package pecrm_pkg;
    // ----------------------------------------
    // geometry and register map
    // ----------------------------------------
    localparam int          NPORT       = 16;      // port copies
    localparam int          AW          = 16;      // address width
    localparam int          DW          = 32;      // data width
    localparam logic [15:0] OFF_CAP2    = 16'h1054; // bytes 8..11
    localparam logic [15:0] OFF_CAP3    = 16'h1058; // bytes 12..15
    localparam logic [15:0] OFF_RATE    = 16'h1068; // rate monitor
    localparam logic [15:0] OFF_THR     = 16'h106C; // trigger levels
    localparam logic [15:0] PORT_STRIDE = 16'h0040; // per-port step
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [31:0] RST_CAP  = 32'h0000_0000;
    localparam logic [31:0] RST_RATE = 32'h8000_0000;
    localparam logic [31:0] RST_THR  = 32'hFFFF_0000;
    // ----------------------------------------
    // field positions (lsb-0 numbering)
    // ----------------------------------------
    localparam int BIAS_LO = 24; // bias select, 8 bits
    localparam int RR_LO   = 16; // recovery select, 2 bits
    localparam int PEAK_LO = 8;  // peak, 8 bits
    localparam int CNT_LO  = 0;  // leaky counter, 8 bits
    localparam int FT_LO   = 24; // failed trigger, 8 bits
    localparam int DT_LO   = 16; // degraded trigger, 8 bits
    // ----------------------------------------
    // bias and recovery codes
    // ----------------------------------------
    localparam logic [7:0] BIAS_OFF = 8'h00;
    localparam logic [7:0] BIAS_01  = 8'h01;
    localparam logic [7:0] BIAS_02  = 8'h02;
    localparam logic [7:0] BIAS_04  = 8'h04;
    localparam logic [7:0] BIAS_08  = 8'h08;
    localparam logic [7:0] BIAS_10  = 8'h10;
    localparam logic [7:0] BIAS_20  = 8'h20;
    localparam logic [7:0] BIAS_40  = 8'h40;
    localparam logic [7:0] BIAS_80  = 8'h80;
    localparam logic [7:0] BIAS_FF  = 8'hFF;
    localparam logic [1:0] RR_2     = 2'h0;
    localparam logic [1:0] RR_4     = 2'h1;
    localparam logic [1:0] RR_16    = 2'h2;
    localparam logic [1:0] RR_NONE  = 2'h3;
    localparam logic [7:0] EXC_2    = 8'h02;
    localparam logic [7:0] EXC_4    = 8'h04;
    localparam logic [7:0] EXC_16   = 8'h10;
    localparam logic [7:0] CNT_MAX  = 8'hFF;
    // ----------------------------------------
    // decrement periods, in ns, and cycles
    // ----------------------------------------
    localparam int          DIV_W    = 42;          // period counter
    localparam longint      CLK_NS   = 10;          // 100 MHz bus clock
    localparam longint      T01_NS   = 1_310_000;   // 1.31 ms
    localparam longint      T02_NS   = 10_480_000;  // 10.48 ms
    localparam longint      T04_NS   = 83_880_000;  // 83.88 ms
    localparam longint      T08_NS   = 1_342_000_000; // 1.342 s
    localparam longint      T10_NS   = 64'd10_740_000_000; // 10.74 s
    localparam longint      T20_NS   = 64'd86_000_000_000; // 86 s
    localparam longint      T40_NS   = 64'd1_374_000_000_000; // 1374 s
    localparam longint      T80_NS   = 64'd10_995_000_000_000; // 10995 s
    localparam longint      TFF_NS   = 1_280;       // 1.28 us
    localparam logic [DIV_W-1:0] CYC01 = DIV_W'(T01_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYC02 = DIV_W'(T02_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYC04 = DIV_W'(T04_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYC08 = DIV_W'(T08_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYC10 = DIV_W'(T10_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYC20 = DIV_W'(T20_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYC40 = DIV_W'(T40_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYC80 = DIV_W'(T80_NS / CLK_NS);
    localparam logic [DIV_W-1:0] CYCFF = DIV_W'(TFF_NS / CLK_NS);
endpackage : pecrm_pkg

// [verif/pecrm_monitor.sv]
`timescale 1ns/100ps
module pecrm_monitor
    import pecrm_pkg::*;
(
    // clock and reset
    input wire logic                     mclk,
    input wire logic                     reset_n,
    // register bus
    input wire logic [AW-1:0]            reg_addr,
    input wire logic [DW-1:0]            reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [DW-1:0]            reg_rdata,
    // error side and reports
    input wire logic [NPORT-1:0]         err_event,
    input wire logic [NPORT-1:0]         capture_stb,
    input wire logic [NPORT-1:0][DW-1:0] capture_word_two_in,
    input wire logic [NPORT-1:0][DW-1:0] capture_word_three_in,
    input wire logic [NPORT-1:0]         failed_report,
    input wire logic [NPORT-1:0]         degraded_report
);
    // ----------------------------------------
    // one clock domain
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // read data only in the cycle after a read
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    // misaligned places read as zero
    property p_unmapped;
        $past(reg_rd) && $past(reg_addr[1:0]) != 2'h0 |-> reg_rdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // reserved bits of the rate word read zero
    property p_rate_rsv;
        $past(reg_rd) && $past(reg_addr) == OFF_RATE |-> reg_rdata[23:18] == 6'h00;
    endproperty
    a_rate_rsv: assert property (p_rate_rsv) else $error("reserved rate bits set");
    // captured bytes 8..11 visible on an immediate read
    property p_cap_two;
        capture_stb[0] ##1 (reg_rd && reg_addr == OFF_CAP2 && !capture_stb[0])
            |=> reg_rdata == $past(capture_word_two_in[0], 2);
    endproperty
    a_cap_two: assert property (p_cap_two) else $error("capture two wrong");
    // captured bytes 12..15 visible on an immediate read
    property p_cap_three;
        capture_stb[0] ##1 (reg_rd && reg_addr == OFF_CAP3 && !capture_stb[0])
            |=> reg_rdata == $past(capture_word_three_in[0], 2);
    endproperty
    a_cap_three: assert property (p_cap_three) else $error("capture three wrong");
    // last port copy sits fifteen strides up
    property p_port_last;
        (reg_wr && reg_addr == 16'h1414 && !capture_stb[15]) ##1
            (reg_rd && reg_addr == 16'h1414 && !capture_stb[15])
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_port_last: assert property (p_port_last) else $error("port 15 copy wrong");
    // written peak and counter read back at once
    property p_rate_wr;
        (reg_wr && reg_addr == OFF_RATE && !err_event[0]) ##1
            (reg_rd && reg_addr == OFF_RATE && !err_event[0])
            |=> reg_rdata == ($past(reg_wdata, 2) & 32'hFF03_FFFF);
    endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("rate write lost");
    // counter zero never equals the reset trigger
    property p_rst_rep;
        $rose(reset_n) |-> failed_report == '0 && degraded_report == '0;
    endproperty
    a_rst_rep: assert property (p_rst_rep) else $error("report after reset");
endmodule : pecrm_monitor

bind pecrm_top pecrm_monitor pecrm_monitor_i (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .err_event(err_event), .capture_stb(capture_stb),
    .capture_word_two_in(capture_word_two_in),
    .capture_word_three_in(capture_word_three_in),
    .failed_report(failed_report), .degraded_report(degraded_report));

// [verif/pecrm_far.sv]
`timescale 1ns/100ps
module pecrm_far
    import pecrm_pkg::*;
(
    // clock
    input wire logic                   mclk,
    // error detection outputs
    output logic [NPORT-1:0]           err_event,
    output logic [NPORT-1:0]           capture_stb,
    output logic [NPORT-1:0][DW-1:0]   capture_word_two_in,
    output logic [NPORT-1:0][DW-1:0]   capture_word_three_in
);
    // quiet lines at time zero
    initial begin
        err_event             = '0;
        capture_stb           = '0;
        capture_word_two_in   = '0;
        capture_word_three_in = '0;
    end
    // one error per cycle, back to back
    task automatic errs(input int p, input int n);
        repeat (n) begin
            @(posedge mclk);
            err_event[p] <= 1'b1;
        end
        @(posedge mclk);
        err_event[p] <= 1'b0;
    endtask : errs
    // one capture pulse; words invert once no longer held
    task automatic capture(input int p, input logic [DW-1:0] w2, input logic [DW-1:0] w3);
        @(posedge mclk);
        capture_word_two_in[p]   <= w2;
        capture_word_three_in[p] <= w3;
        capture_stb[p]           <= 1'b1;
        @(posedge mclk);
        capture_stb[p]           <= 1'b0;
        capture_word_two_in[p]   <= ~w2;
        capture_word_three_in[p] <= ~w3;
    endtask : capture
endmodule : pecrm_far

// [verif/tb.sv]
`timescale 1ns/100ps
module tb
    import pecrm_pkg::*;
;
    // ----------------------------------------
    // signals and counters
    // ----------------------------------------
    logic                     mclk      = 1'b0; // bus clock
    logic                     reset_n   = 1'b0; // sync reset
    logic [AW-1:0]            reg_addr  = '0;   // bus address
    logic [DW-1:0]            reg_wdata = '0;   // bus write data
    logic                     reg_wr    = 1'b0; // write strobe
    logic                     reg_rd    = 1'b0; // read strobe
    logic [DW-1:0]            reg_rdata;        // read data
    logic [NPORT-1:0]         err_event, capture_stb, failed_report, degraded_report;
    logic [NPORT-1:0][DW-1:0] cw2, cw3;         // capture words
    int                       fails     = 0;
    int                       checked   = 0;
    always #5 mclk = ~mclk;
    // short periods for five codes; 02, 08 and 20 keep their real length
    pecrm_top #(.P_CYC01(42'h28), .P_CYC04(42'h2A), .P_CYC10(42'h2C), .P_CYC40(42'h2E),
        .P_CYC80(42'h2F)) pecrm_top_i (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_event(err_event),
        .capture_stb(capture_stb), .capture_word_two_in(cw2), .capture_word_three_in(cw3),
        .failed_report(failed_report), .degraded_report(degraded_report));
    pecrm_far pecrm_far_i (.mclk(mclk), .err_event(err_event), .capture_stb(capture_stb),
        .capture_word_two_in(cw2), .capture_word_three_in(cw3));
    // ----------------------------------------
    // compare, bus and closing tasks
    // ----------------------------------------
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr
    // read, data taken in the following cycle only
    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rdc
    // write then read with no gap
    task automatic wrrd(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [DW-1:0] e);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge mclk);
        reg_rd    <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : wrrd
    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdc(16'h1054, 32'h0000_0000);
        rdc(16'h1058, 32'h0000_0000);
        rdc(16'h1068, 32'h8000_0000);
        rdc(16'h1428, 32'h8000_0000);
        rdc(16'h106C, 32'hFFFF_0000);
        rdc(16'h1062, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_capture();
        fork
            pecrm_far_i.capture(0, 32'hA1B2_C3D4, 32'h1E2F_3A4B);
            begin
                @(posedge mclk);
                rdc(16'h1054, 32'hA1B2_C3D4);
            end
        join
        fork
            pecrm_far_i.capture(0, 32'hA1B2_C3D4, 32'h1E2F_3A4B);
            begin
                @(posedge mclk);
                rdc(16'h1058, 32'h1E2F_3A4B);
            end
        join
        rdc(16'h1114, 32'h0000_0000);
        wrrd(16'h1414, 32'h5A5A_0F0F, 32'h5A5A_0F0F);
        rdc(16'h1054, 32'hA1B2_C3D4);
        $display("test capture done");
    endtask : t_capture
    // each bias code from counter 4, about 100 or 300 cycles; codes 00, 02, 08 and 20 leave 4
    task automatic t_decay();
        logic [7:0] code [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08,
                                  8'h10, 8'h20, 8'h40, 8'h80, 8'hFF};
        logic [7:0] left [10] = '{8'h04, 8'h02, 8'h04, 8'h02, 8'h04,
                                  8'h02, 8'h04, 8'h02, 8'h02, 8'h02};
        for (int i = 0; i < 10; i++) begin
            wr(OFF_RATE, {code[i], 24'h00_0404});
            repeat (code[i] == 8'hFF ? 300 : 96) @(posedge mclk);
            rdc(OFF_RATE, {code[i], 16'h0004, left[i]});
        end
        $display("test decay done");
    endtask : t_decay
    // ceilings above failed trigger 3, then saturation and disable
    task automatic t_recover();
        logic [7:0] ceil [4] = '{8'h05, 8'h07, 8'h13, 8'h14};
        wr(16'h106C, 32'h0302_0000);
        for (int i = 0; i < 4; i++) begin
            wrrd(OFF_RATE, {14'h0000, i[1:0], 16'h0000}, {14'h0000, i[1:0], 16'h0000});
            pecrm_far_i.errs(0, 2);
            @(posedge mclk);
            #1 check({30'h0, failed_report[0], degraded_report[0]}, 32'h0000_0001);
            pecrm_far_i.errs(0, 1);
            @(posedge mclk);
            #1 check({30'h0, failed_report[0], degraded_report[0]}, 32'h0000_0002);
            pecrm_far_i.errs(0, 17);
            rdc(OFF_RATE, {14'h0000, i[1:0], ceil[i], ceil[i]});
        end
        pecrm_far_i.errs(0, 240);
        rdc(OFF_RATE, 32'h0003_FFFF);
        wr(16'h106C, 32'h0000_0000);
        wr(OFF_RATE, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        #1 check({30'h0, failed_report[0], degraded_report[0]}, 32'h0000_0000);
        $display("test recover done");
    endtask : t_recover
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_capture();
        t_decay();
        t_recover();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        end_sim();
    end
endmodule : tb
